/* File: src/lmpc_pkg.sv */
// Constants for the mode and panel power control register block.
// Assumes a 20 MHz system clock and an APB master with 32-bit data.
//
// Contract
// RULE1: With table bypass clear, gray data goes through the green table.
// RULE2: With table bypass set, gray data goes to the panel untranslated.
// RULE3: In color modes the table is always used, bypass is ignored.
// RULE4: With override clear, the sequencer drives panel power and signals.
// RULE5: With override set, entering power save drops power and signals now.
// RULE6: Hardware power save enable turns pin zero into a high-true input.
// RULE7: Otherwise pin zero is an input read back, or drives its control bit.
// RULE8: Field value 00 is power save, 11 normal, 01 and 10 are reserved.
package lmpc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned SEQ_TIME_US = 100;
  localparam int unsigned SEQ_CYC     = (CLK_HZ / 1_000_000) * SEQ_TIME_US;
  localparam int unsigned CNT_W       = 11;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [15:0] IDX_MODE     = 16'hFFE3;
  localparam logic [15:0] IDX_GPIO_CFG = 16'hFFF8;
  localparam logic [15:0] IDX_GPIO_CTL = 16'hFFF9;
  localparam logic [15:0] IDX_LUT_ADR  = 16'hFF80;
  localparam logic [15:0] IDX_LUT_DAT  = 16'hFF81;
  localparam logic [31:0] ADDR_MODE     = {14'h0000, IDX_MODE, 2'h0};
  localparam logic [31:0] ADDR_GPIO_CFG = {14'h0000, IDX_GPIO_CFG, 2'h0};
  localparam logic [31:0] ADDR_GPIO_CTL = {14'h0000, IDX_GPIO_CTL, 2'h0};
  localparam logic [31:0] ADDR_LUT_ADR  = {14'h0000, IDX_LUT_ADR, 2'h0};
  localparam logic [31:0] ADDR_LUT_DAT  = {14'h0000, IDX_LUT_DAT, 2'h0};

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int unsigned BIT_BYPASS   = 7;
  localparam int unsigned BIT_OVERRIDE = 3;
  localparam int unsigned BIT_HWPS_EN  = 2;
  localparam int unsigned BIT_SWPS_HI  = 1;
  localparam int unsigned BIT_SWPS_LO  = 0;
  localparam logic [7:0]  MODE_WMASK   = 8'h8F;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic        GPIO_CFG_RST = 1'h0;
  localparam logic        GPIO_CTL_RST = 1'h0;
  localparam logic [3:0]  LUT_ADR_RST  = 4'h0;
  localparam logic [1:0]  SWPS_SAVE    = 2'h0;
  localparam logic [1:0]  SWPS_NORMAL  = 2'h3;
  localparam int unsigned LUT_DEPTH    = 16;
  localparam int unsigned PIX_W        = 4;
  localparam int unsigned CTL_W        = 3;

  typedef enum logic [1:0] {
    ST_ON,
    ST_DOWN,
    ST_OFF,
    ST_UP
  } lmpc_seq_e;

endpackage

/* File: src/lmpc_top.sv */
// Mode and panel power control register block with APB slave.
// Assumes pixel and panel control inputs synchronous to clock_i.
//
// The APB interface to the registers was left to the implementer.
module lmpc_top (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [31:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic                           pready_o,
  output logic      [31:0]               prdata_o,
  output logic                           pslverr_o,
  input  wire logic                      color_mode_i,
  input  wire logic [lmpc_pkg::PIX_W-1:0] pixel_i,
  input  wire logic [lmpc_pkg::CTL_W-1:0] panel_ctl_i,
  output logic      [lmpc_pkg::PIX_W-1:0] panel_data_o,
  output logic      [lmpc_pkg::CTL_W-1:0] panel_ctl_o,
  output logic                           panel_power_output_o,
  input  wire logic                      shared_io_pin_zero_i,
  output logic                           shared_io_pin_zero_o,
  output logic                           shared_io_pin_zero_oe_o
);

  // ************************************************************
  // Decoding
  // ************************************************************
  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a == lmpc_pkg::ADDR_MODE) ||
                  (a == lmpc_pkg::ADDR_GPIO_CFG) ||
                  (a == lmpc_pkg::ADDR_GPIO_CTL) ||
                  (a == lmpc_pkg::ADDR_LUT_ADR) ||
                  (a == lmpc_pkg::ADDR_LUT_DAT);
  endfunction

  // Reserved field codes act as normal operation
  function automatic logic sw_save(input logic [1:0] f);
    sw_save = (f == lmpc_pkg::SWPS_SAVE);
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0]                 mode_ff;
  logic                       gpio_cfg_ff;
  logic                       gpio_ctl_ff;
  logic [3:0]                 lut_adr_ff;
  logic [lmpc_pkg::PIX_W-1:0] lut_ff [lmpc_pkg::LUT_DEPTH];
  logic                       pready_ff;
  logic [31:0]                prdata_ff;
  logic                       pslverr_ff;
  logic                       oe_ff;
  logic                       out_ff;
  logic                       power_ff;
  logic [lmpc_pkg::CTL_W-1:0] ctl_ff;
  logic [lmpc_pkg::PIX_W-1:0] data_ff;
  lmpc_pkg::lmpc_seq_e        state_ff;
  logic [lmpc_pkg::CNT_W-1:0] cnt_ff;

  // ************************************************************
  // Sequencer decoding
  // ************************************************************
  // Last count of a timed power up or power down step
  localparam logic [lmpc_pkg::CNT_W-1:0] SEQ_LAST =
    lmpc_pkg::CNT_W'(lmpc_pkg::SEQ_CYC - 1);

  // Override skips the timed power down step
  function automatic lmpc_pkg::lmpc_seq_e next_seq(
    input lmpc_pkg::lmpc_seq_e st,
    input logic                save,
    input logic                ovr,
    input logic                done
  );
    next_seq = st;
    case (st)
      lmpc_pkg::ST_ON: begin
        if (save && ovr) begin
          next_seq = lmpc_pkg::ST_OFF; // [RULE5]
        end else if (save) begin
          next_seq = lmpc_pkg::ST_DOWN; // [RULE4]
        end
      end
      lmpc_pkg::ST_DOWN: begin
        if (save && ovr) begin
          next_seq = lmpc_pkg::ST_OFF; // [RULE5]
        end else if (!save) begin
          next_seq = lmpc_pkg::ST_ON;
        end else if (done) begin
          next_seq = lmpc_pkg::ST_OFF; // [RULE4]
        end
      end
      lmpc_pkg::ST_OFF: begin
        if (!save) begin
          next_seq = lmpc_pkg::ST_UP;
        end
      end
      lmpc_pkg::ST_UP: begin
        // Signals are still low, so power may drop at once
        if (save) begin
          next_seq = lmpc_pkg::ST_OFF;
        end else if (done) begin
          next_seq = lmpc_pkg::ST_ON;
        end
      end
      default: begin
        next_seq = lmpc_pkg::ST_OFF;
      end
    endcase
  endfunction

  // ************************************************************
  // Bus phase and register select
  // ************************************************************
  logic        access;
  logic        hit;
  logic        wr_stb;
  logic        wr_mode;
  logic        wr_cfg;
  logic        wr_ctl;
  logic        wr_ladr;
  logic        wr_ldat;
  logic [31:0] read_mux;

  assign access  = psel_i && penable_i;
  assign hit     = addr_mapped(paddr_i);
  // Writes land only on the edge that completes the access
  assign wr_stb  = access && pready_ff && pwrite_i && pstrb_i[0] && hit;
  assign wr_mode = wr_stb && (paddr_i == lmpc_pkg::ADDR_MODE);
  assign wr_cfg  = wr_stb && (paddr_i == lmpc_pkg::ADDR_GPIO_CFG);
  assign wr_ctl  = wr_stb && (paddr_i == lmpc_pkg::ADDR_GPIO_CTL);
  assign wr_ladr = wr_stb && (paddr_i == lmpc_pkg::ADDR_LUT_ADR);
  assign wr_ldat = wr_stb && (paddr_i == lmpc_pkg::ADDR_LUT_DAT);

  // ************************************************************
  // Mode fields and power save request
  // ************************************************************
  logic                       bypass;
  logic                       override;
  logic                       hwps_en;
  logic [1:0]                 swps;
  logic                       save_req;
  logic                       use_lut;
  logic                       cnt_done;
  logic                       pin_read;
  lmpc_pkg::lmpc_seq_e        nxt_state;
  logic [lmpc_pkg::PIX_W-1:0] lut_out;
  logic [lmpc_pkg::PIX_W-1:0] nxt_data;

  assign bypass   = mode_ff[lmpc_pkg::BIT_BYPASS];
  assign override = mode_ff[lmpc_pkg::BIT_OVERRIDE];
  assign hwps_en  = mode_ff[lmpc_pkg::BIT_HWPS_EN];
  assign swps     = mode_ff[lmpc_pkg::BIT_SWPS_HI:lmpc_pkg::BIT_SWPS_LO];
  // Reserved codes keep the panel running
  assign save_req = sw_save(swps) ||                   // [RULE8]
                    (hwps_en && shared_io_pin_zero_i); // [RULE6]
  // GPIO settings are ignored while the pin is a power save input
  assign pin_read = (gpio_cfg_ff && !hwps_en) ? gpio_ctl_ff
                                              : shared_io_pin_zero_i; // [RULE7]
  assign cnt_done  = (cnt_ff == SEQ_LAST);
  assign nxt_state = next_seq(state_ff, save_req, override, cnt_done);

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    read_mux = 32'h00000000;
    case (paddr_i)
      lmpc_pkg::ADDR_MODE: begin
        read_mux = {24'h000000, mode_ff};
      end
      lmpc_pkg::ADDR_GPIO_CFG: begin
        read_mux = {31'h00000000, gpio_cfg_ff};
      end
      lmpc_pkg::ADDR_GPIO_CTL: begin
        read_mux = {31'h00000000, pin_read}; // [RULE7]
      end
      lmpc_pkg::ADDR_LUT_ADR: begin
        read_mux = {28'h0000000, lut_adr_ff};
      end
      lmpc_pkg::ADDR_LUT_DAT: begin
        read_mux = {28'h0000000, lut_ff[lut_adr_ff]};
      end
      default: begin
        read_mux = 32'h00000000;
      end
    endcase
  end

  // ************************************************************
  // Bus response
  // ************************************************************
  // One wait state: ready rises on the second access cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_ff <= 1'h0;
    end else begin
      pready_ff <= access && !pready_ff;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_ff <= 32'h00000000;
    end else if (access && !pready_ff) begin
      prdata_ff <= read_mux;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pslverr_ff <= 1'h0;
    end else begin
      pslverr_ff <= access && !pready_ff && !hit;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_ff <= lmpc_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= pwdata_i[7:0] & lmpc_pkg::MODE_WMASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gpio_cfg_ff <= lmpc_pkg::GPIO_CFG_RST;
    end else if (wr_cfg) begin
      gpio_cfg_ff <= pwdata_i[0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gpio_ctl_ff <= lmpc_pkg::GPIO_CTL_RST;
    end else if (wr_ctl) begin
      gpio_ctl_ff <= pwdata_i[0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lut_adr_ff <= lmpc_pkg::LUT_ADR_RST;
    end else if (wr_ladr) begin
      lut_adr_ff <= pwdata_i[3:0];
    end
  end

  // ************************************************************
  // Green look-up table
  // ************************************************************
  // Identity after reset, so an unloaded table passes data as is
  for (genvar g = 0; g < lmpc_pkg::LUT_DEPTH; g++) begin : g_lut
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        lut_ff[g] <= lmpc_pkg::PIX_W'(g);
      end else if (wr_ldat && (lut_adr_ff == 4'(g))) begin
        lut_ff[g] <= pwdata_i[lmpc_pkg::PIX_W-1:0];
      end
    end
  end

  assign lut_out = lut_ff[pixel_i];
  // Color modes always translate; bypass is a gray-only power saver
  assign use_lut  = color_mode_i || !bypass; // [RULE1] [RULE3]
  assign nxt_data = use_lut ? lut_out : pixel_i; // [RULE2]

  // ************************************************************
  // Panel power sequencer
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= lmpc_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (((state_ff == lmpc_pkg::ST_DOWN) ||
                  (state_ff == lmpc_pkg::ST_UP)) && !cnt_done) begin
      cnt_ff <= cnt_ff + lmpc_pkg::CNT_W'(1);
    end else begin
      cnt_ff <= '0;
    end
  end

  // Outputs follow the next state so an override acts in one cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      power_ff <= 1'h0;
    end else begin
      power_ff <= (nxt_state != lmpc_pkg::ST_OFF); // [RULE4] [RULE5]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_ff <= '0;
    end else if (nxt_state == lmpc_pkg::ST_ON) begin
      ctl_ff <= panel_ctl_i;
    end else begin
      ctl_ff <= '0; // [RULE5]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_ff <= '0;
    end else if (nxt_state == lmpc_pkg::ST_ON) begin
      data_ff <= nxt_data;
    end else begin
      data_ff <= '0; // [RULE5]
    end
  end

  // ************************************************************
  // Shared pin zero
  // ************************************************************
  // Pin stays an input through reset and in hardware power save
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oe_ff <= 1'h0;
    end else begin
      oe_ff <= gpio_cfg_ff && !hwps_en; // [RULE6] [RULE7]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_ff <= 1'h0;
    end else begin
      out_ff <= gpio_ctl_ff; // [RULE7]
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign pready_o                = pready_ff;
  assign prdata_o                = prdata_ff;
  assign pslverr_o               = pslverr_ff;
  assign panel_data_o            = data_ff;
  assign panel_ctl_o             = ctl_ff;
  assign panel_power_output_o    = power_ff;
  assign shared_io_pin_zero_o    = out_ff;
  assign shared_io_pin_zero_oe_o = oe_ff;

endmodule

/* File: verification/lmpc_pin_model.sv */
// Pin zero wire model: a resistor to a level that the bench picks
// Assumes the block's output enable is high while it drives
module lmpc_pin_model (
  input  wire logic oe_i,
  input  wire logic out_i,
  input  wire logic pull_i,
  output logic      pin_o
);
  // Undriven pin settles to the resistor level, never floats
  assign pin_o = oe_i ? out_i : pull_i;
endmodule

/* File: verification/lmpc_assertions.sv */
// Port checker bound to lmpc_top; one clock, synchronous reset
module lmpc_chk (input wire logic clock_i, rst_i, psel_i, penable_i,
  input wire logic pready_o, pslverr_o, panel_power_output_o,
  input wire logic shared_io_pin_zero_oe_o,
  input wire logic [lmpc_pkg::CTL_W-1:0] panel_ctl_o,
  input wire logic [lmpc_pkg::PIX_W-1:0] panel_data_o);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_rdy; psel_i && penable_i |-> ##[0:50] pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_off; !panel_power_output_o |-> !panel_ctl_o; endproperty
  a_off: assert property (p_off) else $error("signals without power");
  property p_rst; $fell(rst_i) |-> !shared_io_pin_zero_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("pin driven at reset");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_req; pready_o |-> $past(psel_i && penable_i); endproperty
  a_req: assert property (p_req) else $error("pready without access");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without pready");
  property p_data; !panel_power_output_o |-> (panel_data_o == '0);
  endproperty
  a_data: assert property (p_data) else $error("data without power");
  property p_up; $rose(panel_power_output_o) |-> (panel_ctl_o == '0);
  endproperty
  a_up: assert property (p_up) else $error("signals before power");
  c_rdy: cover property (pready_o);
  c_off: cover property (!panel_power_output_o);
  c_oe: cover property (shared_io_pin_zero_oe_o);
endmodule
bind lmpc_top lmpc_chk i_chk (.clock_i, .rst_i, .psel_i, .penable_i,
  .pready_o, .pslverr_o, .panel_power_output_o, .shared_io_pin_zero_oe_o,
  .panel_ctl_o, .panel_data_o);

/* File: verification/tb.sv */
// Bench for lmpc_top: register rows over APB, pin zero, override
// Assumes the APB slave answers well inside the cycle ceiling
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0, rst_i = 1'h1, sel = 1'h0, en = 1'h0, wr = 1'h0;
  logic cm = 1'h0, pull = 1'h1, pin, rdy, oe, po, pout, err, er;
  logic [31:0] ad = 32'h0, wd = 32'h0, rd, prd;
  logic [3:0] pd;
  logic [2:0] pc;
  int errors = 0, checked = 0, cyc = 0;
  logic [95:0] rows [7] = '{{lmpc_pkg::ADDR_MODE, 32'hFF, 32'h8F},
    {lmpc_pkg::ADDR_MODE, 32'h0, 32'h0},
    {lmpc_pkg::ADDR_GPIO_CFG, 32'h0, 32'h0},
    {lmpc_pkg::ADDR_GPIO_CTL, 32'h0, 32'h1},
    {lmpc_pkg::ADDR_GPIO_CFG, 32'h1, 32'h1},
    {lmpc_pkg::ADDR_LUT_ADR, 32'hA, 32'hA},
    {lmpc_pkg::ADDR_LUT_DAT, 32'h5, 32'h5}};
  lmpc_top i_lmpc_top (.clock_i, .rst_i, .psel_i(sel), .penable_i(en),
    .pwrite_i(wr), .paddr_i(ad), .pwdata_i(wd), .pstrb_i(4'hF),
    .pready_o(rdy), .prdata_o(prd), .pslverr_o(err), .color_mode_i(cm),
    .pixel_i(4'hA), .panel_ctl_i(3'h7), .panel_data_o(pd), .panel_ctl_o(pc),
    .panel_power_output_o(po), .shared_io_pin_zero_i(pin),
    .shared_io_pin_zero_o(pout), .shared_io_pin_zero_oe_o(oe));
  lmpc_pin_model i_lmpc_pin_model (.oe_i(oe), .out_i(pout), .pull_i(pull),
    .pin_o(pin));
  initial forever #25 clock_i = ~clock_i;
  // Called just after a rising edge; returns just after one
  task automatic xfer(input logic [31:0] a, d, input logic w);
    sel <= 1'h1;
    en <= 1'h0;
    ad <= a;
    wd <= d;
    wr <= w;
    @(posedge clock_i);
    en <= 1'h1;
    do @(posedge clock_i); while (rdy !== 1'h1);
    rd = prd;
    er = err;
    sel <= 1'h0;
    en <= 1'h0;
    @(posedge clock_i);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task summarize;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 12000) begin
    errors++;
    summarize();
  end
  initial begin
    settle(20);
    cmp("reset pins", 32'h0, {oe, po, pc, pd});
    rst_i <= 1'h0;
    settle(1);
    foreach (rows[i]) begin
      xfer(rows[i][95:64], rows[i][63:32], 1'h1);
      xfer(rows[i][95:64], 32'h0, 1'h0);
      cmp("register", rows[i][31:0], rd);
    end
    xfer(lmpc_pkg::ADDR_GPIO_CTL, 32'h1, 1'h1);
    settle(2);
    cmp("pin drive", 32'h3, {oe, pout});
    xfer(lmpc_pkg::ADDR_GPIO_CFG, 32'h0, 1'h1);
    pull <= 1'h0;
    settle(2);
    xfer(lmpc_pkg::ADDR_GPIO_CTL, 32'h0, 1'h0);
    cmp("pin read", 32'h0, rd);
    pull <= 1'h1;
    xfer(32'h00000010, 32'h0, 1'h0);
    cmp("slave error", 32'h1, er);
    xfer(lmpc_pkg::ADDR_MODE, 32'h01, 1'h1);
    settle(lmpc_pkg::SEQ_CYC + 4);
    cmp("panel on", 32'hF, {po, pc});
    cmp("gray table", 32'h5, pd);
    xfer(lmpc_pkg::ADDR_MODE, 32'h81, 1'h1);
    settle(3);
    cmp("gray bypass", 32'hA, pd);
    cm <= 1'h1;
    settle(3);
    cmp("color table", 32'h5, pd);
    cm <= 1'h0;
    xfer(lmpc_pkg::ADDR_MODE, 32'h00, 1'h1);
    settle(3);
    cmp("power down step", 32'h8, {po, pc});
    settle(lmpc_pkg::SEQ_CYC + 4);
    cmp("panel off", 32'h0, {po, pc});
    xfer(lmpc_pkg::ADDR_MODE, 32'h03, 1'h1);
    settle(lmpc_pkg::SEQ_CYC + 4);
    xfer(lmpc_pkg::ADDR_MODE, 32'h08, 1'h1);
    settle(3);
    cmp("override off", 32'h0, {po, pc, pd});
    xfer(lmpc_pkg::ADDR_GPIO_CFG, 32'h1, 1'h1);
    pull <= 1'h0;
    xfer(lmpc_pkg::ADDR_MODE, 32'h07, 1'h1);
    settle(lmpc_pkg::SEQ_CYC + 4);
    cmp("hw input only", 32'hF, {oe, po, pc});
    pull <= 1'h1;
    settle(3);
    cmp("hw power save", 32'h8, {oe, po, pc});
    rst_i <= 1'h1;
    settle(3);
    cmp("reset pins", 32'h0, {oe, po, pc, pd});
    rst_i <= 1'h0;
    settle(1);
    xfer(lmpc_pkg::ADDR_MODE, 32'h0, 1'h0);
    cmp("reset mode", 32'h0, rd);
    summarize();
  end
endmodule
